//--- rtl/pll_ref_select_and_dividers.sv
// pll reference front end: enables, switchover, deglitch, r and n dividers
// assumes: reference pins are asynchronous and sampled at 200 MHz; vco_tick
// is a one-cycle pulse per vco edge from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - all reference inputs off after reset
// - receivers power down by mode and pll state
// - offset bit lowers single-ended bias point
// - manual or automatic selection in dual mode
// - manual select from register or pin
// - monitor pin high while primary invalid
// - deglitch blocks misaligned edges, can be disabled
// - automatic selection always reverts to preferred
// - 14-bit reference divider, zero and one divide one
// - reference divider reset by three sources
// - feedback ratio is modulus times main plus swallow
// - prescaler fixed and dual modulus modes
// - fixed modes treat swallow count as zero
// - feedback ratio reaches 1 to 262175
// - main count three or bypassed, swallow zero real
// - main bypass gives prescaler ratio alone
// - counter reset bits hold until cleared
// - sync pin resets counters when enabled
// - crystal amplifier follows its enable bit
module pll_ref_select_and_dividers
   import pll_ref_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // reference and control pins
   input wire logic ref_pin_p,
   input wire logic ref_pin_n,
   input wire logic ref_sel_pin,
   input wire logic sync_n_pin,
   // feedback side
   input wire logic vco_tick,
   input wire logic pll_powered_down,
   input wire logic [SWALLOW_W-1:0] swallow_count,
   input wire logic [MAIN_W-1:0] main_count,
   // divided outputs toward the phase detector
   output logic ref_to_detector,
   output logic feedback_to_detector,
   // monitor pin and analog controls
   output logic reference_monitor_pin,
   output logic diff_rx_power_on,
   output logic se1_power_on,
   output logic se2_power_on,
   output logic crystal_amplifier_enable,
   output logic se_offset_enable
);

   // register storage
   reg_byte_t ref_div_low_q;
   reg_byte_t ref_div_high_q;
   reg_byte_t presc_ctrl_q;
   reg_byte_t lock_offset_q;
   reg_byte_t sync_ctrl_q;
   reg_byte_t monitor_ctrl_q;
   reg_byte_t ref_sel_q;
   reg_byte_t rd_val; // read mux output

   // write strobes per register
   wire wr_div_low = reg_wr && (reg_addr == OFS_REF_DIV_LOW);
   wire wr_div_high = reg_wr && (reg_addr == OFS_REF_DIV_HIGH);
   wire wr_presc = reg_wr && (reg_addr == OFS_PRESC_MODE);
   wire wr_lock = reg_wr && (reg_addr == OFS_LOCK_OFFSET);
   wire wr_sync = reg_wr && (reg_addr == OFS_SYNC_RESET);
   wire wr_mon = reg_wr && (reg_addr == OFS_MONITOR_PIN);
   wire wr_sel = reg_wr && (reg_addr == OFS_REF_SELECT);

   // synchronised pins: {sync_n, ref_sel, ref_n, ref_p}
   logic [3:0] pins_s;
   pin_sync2 #(.W(4), .RST_VAL(4'h8)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in({sync_n_pin, ref_sel_pin, ref_pin_n, ref_pin_p}),
      .pin_sync(pins_s)
   );
   wire [1:0] ref_s = pins_s[1:0]; // primary, secondary levels
   wire ref_sel_s = pins_s[2];
   wire sync_n_s = pins_s[3];

   // decoded control views
   ref_ctrl_s ctrl;
   assign ctrl = ref_ctrl_s'(ref_sel_q);
   presc_mode_e presc_mode;
   assign presc_mode = presc_mode_e'(presc_ctrl_q[PRESC_MSB:PRESC_LSB]);

   // power and enable decode, registered below
   ref_power_s pwr_d;
   ref_power_s pwr_q;
   always_comb begin
      pwr_d.diff_rx_on = ctrl.diff_en && !pll_powered_down;
      pwr_d.se1_on = ctrl.primary_en && !ctrl.diff_en
                     && !pll_powered_down;
      pwr_d.se2_on = ctrl.secondary_en && !ctrl.diff_en
                     && !pll_powered_down;
      pwr_d.crystal_on = ctrl.crystal_en;
      pwr_d.se_offset_on = lock_offset_q[SE_OFFSET_BIT];
   end

   // per-input edge detect, gated by buffer power
   logic [1:0] ref_prev_q;
   wire [1:0] se_on = {pwr_q.se2_on, pwr_q.se1_on};
   wire [1:0] ref_rise = ref_s & ~ref_prev_q & se_on;

   // activity monitors: input invalid after a timeout with no edge
   logic [1:0] ref_valid;
   for (genvar gi = 0; gi < 2; gi++) begin : g_loss
      logic [LOSS_W-1:0] idle_q; // cycles since last rising edge
      // restart on edge, saturate at the limit
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            idle_q <= LOSS_LIMIT;
         end else if (ref_rise[gi]) begin
            idle_q <= '0;
         end else if (idle_q < LOSS_LIMIT) begin
            idle_q <= idle_q + LOSS_W'(1);
         end
      end
      assign ref_valid[gi] = idle_q < LOSS_LIMIT;
   end

   // monitor pin source select
   logic mon_pin_q;
   wire mon_pri = (monitor_ctrl_q == MON_PRIMARY_BAD) && !ref_valid[0];
   wire mon_sec = (monitor_ctrl_q == MON_SECONDARY_BAD) && !ref_valid[1];
   wire mon_pin_d = mon_pri || mon_sec;

   // wanted reference: 1 means secondary
   wire dual_se = !ctrl.diff_en && ctrl.primary_en
                  && ctrl.secondary_en;
   wire manual_sec = ctrl.pin_select ? ref_sel_s
                     : ctrl.manual_secondary;
   // monitor high leaves the preferred input, low returns: revertive
   wire auto_sec = ctrl.manual_secondary ^ mon_pin_q;
   wire single_sec = !ctrl.diff_en && ctrl.secondary_en
                     && !ctrl.primary_en;
   wire want_sec = dual_se ? (ctrl.auto_en ? auto_sec : manual_sec)
                   : single_sec;

   // selection and deglitch state machine
   sel_state_e sel_q;
   sel_state_e sel_d;
   always_comb begin
      case (sel_q)
         SEL_PRIMARY: begin
            if (!want_sec) sel_d = SEL_PRIMARY;
            else if (ctrl.deglitch_en) sel_d = SEL_BLANK_TO_SEC;
            else sel_d = SEL_SECONDARY;
         end
         SEL_SECONDARY: begin
            if (want_sec) sel_d = SEL_SECONDARY;
            else if (ctrl.deglitch_en) sel_d = SEL_BLANK_TO_PRI;
            else sel_d = SEL_PRIMARY;
         end
         SEL_BLANK_TO_SEC: begin
            // wait for the new input's edge; a dead target stalls here
            if (!want_sec) sel_d = SEL_BLANK_TO_PRI;
            else if (ref_rise[1] || !ctrl.deglitch_en) sel_d = SEL_SECONDARY;
            else sel_d = SEL_BLANK_TO_SEC;
         end
         SEL_BLANK_TO_PRI: begin
            if (want_sec) sel_d = SEL_BLANK_TO_SEC;
            else if (ref_rise[0] || !ctrl.deglitch_en) sel_d = SEL_PRIMARY;
            else sel_d = SEL_BLANK_TO_PRI;
         end
         default: sel_d = SEL_PRIMARY;
      endcase
   end

   // reference level into the r divider, blanked while deglitching
   wire blanking = (sel_q == SEL_BLANK_TO_SEC) || (sel_q == SEL_BLANK_TO_PRI);
   wire on_sec = (sel_q == SEL_SECONDARY) || (sel_q == SEL_BLANK_TO_SEC);
   wire se_level = on_sec ? (ref_s[1] && pwr_q.se2_on)
                   : (ref_s[0] && pwr_q.se1_on);
   wire diff_level = ref_s[0] && pwr_q.diff_rx_on;
   wire ref_level = ctrl.diff_en ? diff_level
                    : (se_level && !blanking);
   logic ref_level_q;
   wire ref_tick = ref_level && !ref_level_q;

   // counter reset sources
   wire sync_req = (sync_ctrl_q[SYNC_EN_MSB:SYNC_EN_LSB] != SYNC_EN_OFF)
                   && !sync_n_s;
   wire r_clear = presc_ctrl_q[R_RESET_BIT]
                  || presc_ctrl_q[SHARED_RESET_BIT] || sync_req;
   wire ab_clear = presc_ctrl_q[AB_RESET_BIT]
                   || presc_ctrl_q[SHARED_RESET_BIT] || sync_req;

   // reference divider
   wire [REF_DIV_W-1:0] ref_ratio =
      {ref_div_high_q[REF_DIV_HIGH_W-1:0], ref_div_low_q};
   div_counter #(.W(REF_DIV_W)) u_ref_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(r_clear),
      .tick(ref_tick),
      .ratio(ref_ratio),
      .wrap(),
      .pulse_q(ref_to_detector)
   );

   // prescaler base modulus and mode kind
   logic [PRESC_W-1:0] p_base;
   always_comb begin
      case (presc_mode)
         PRE_FIXED1: p_base = MOD_1;
         PRE_FIXED2: p_base = MOD_2;
         PRE_FIXED3: p_base = MOD_3;
         PRE_DUAL2: p_base = MOD_2;
         PRE_DUAL4: p_base = MOD_4;
         PRE_DUAL8: p_base = MOD_8;
         PRE_DUAL16: p_base = MOD_16;
         PRE_DUAL32: p_base = MOD_32;
         default: p_base = MOD_1;
      endcase
   end
   wire dual_mode = !(presc_mode inside {PRE_FIXED1, PRE_FIXED2, PRE_FIXED3});

   // swallow count actually used: zero in fixed modes or main bypass
   wire main_bypass = (main_count == MAIN_BYPASS);
   wire [SWALLOW_W-1:0] a_eff = (dual_mode && !main_bypass)
                                ? swallow_count : '0;
   logic [SWALLOW_W-1:0] a_left_q; // swallow cycles left this period
   logic [PRESC_W-1:0] presc_cnt_q;
   wire swallow = (a_left_q != '0);
   wire [PRESC_W-1:0] modulus = p_base
                                + {{(PRESC_W-1){1'b0}}, swallow};
   wire presc_wrap = vco_tick && !ab_clear
                     && (presc_cnt_q >= modulus - PRESC_W'(1));
   logic main_wrap;

   // main counter: one output per main_count prescaler periods
   div_counter #(.W(MAIN_W)) u_main_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(ab_clear),
      .tick(presc_wrap),
      .ratio(main_count),
      .wrap(main_wrap),
      .pulse_q(feedback_to_detector)
   );

   // prescaler and swallow counters
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         presc_cnt_q <= '0;
         a_left_q <= '0;
      end else begin
         if (ab_clear || presc_wrap) begin
            presc_cnt_q <= '0;
         end else if (vco_tick) begin
            presc_cnt_q <= presc_cnt_q + PRESC_W'(1);
         end
         if (ab_clear || main_wrap) begin
            a_left_q <= a_eff;
         end else if (presc_wrap && swallow) begin
            a_left_q <= a_left_q - SWALLOW_W'(1);
         end
      end
   end

   // register writes; reset leaves every input off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ref_div_low_q <= RST_REG;
         ref_div_high_q <= RST_REG;
         presc_ctrl_q <= RST_REG;
         lock_offset_q <= RST_REG;
         sync_ctrl_q <= RST_REG;
         monitor_ctrl_q <= RST_REG;
         ref_sel_q <= RST_REG;
      end else begin
         if (wr_div_low) ref_div_low_q <= reg_wdata;
         if (wr_div_high) ref_div_high_q <= reg_wdata;
         if (wr_presc) presc_ctrl_q <= reg_wdata;
         if (wr_lock) lock_offset_q <= reg_wdata;
         if (wr_sync) sync_ctrl_q <= reg_wdata;
         if (wr_mon) monitor_ctrl_q <= reg_wdata;
         if (wr_sel) ref_sel_q <= reg_wdata;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         OFS_REF_DIV_LOW: rd_val = ref_div_low_q;
         OFS_REF_DIV_HIGH: rd_val = ref_div_high_q;
         OFS_PRESC_MODE: rd_val = presc_ctrl_q;
         OFS_LOCK_OFFSET: rd_val = lock_offset_q;
         OFS_SYNC_RESET: rd_val = sync_ctrl_q;
         OFS_MONITOR_PIN: rd_val = monitor_ctrl_q;
         OFS_REF_SELECT: rd_val = ref_sel_q;
         OFS_REF_STATUS: rd_val = {4'h0, blanking, on_sec, ref_valid};
         default: rd_val = RST_REG;
      endcase
   end

   // state, edge history, outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= SEL_PRIMARY;
         ref_prev_q <= 2'h0;
         ref_level_q <= 1'b0;
         mon_pin_q <= 1'b0;
         pwr_q <= '0;
         reg_rdata <= RST_REG;
      end else begin
         sel_q <= sel_d;
         ref_prev_q <= ref_s;
         ref_level_q <= ref_level;
         mon_pin_q <= mon_pin_d;
         pwr_q <= pwr_d;
         if (reg_rd) reg_rdata <= rd_val;
      end
   end

   // analog control pins straight from their flops
   assign reference_monitor_pin = mon_pin_q;
   assign diff_rx_power_on = pwr_q.diff_rx_on;
   assign se1_power_on = pwr_q.se1_on;
   assign se2_power_on = pwr_q.se2_on;
   assign crystal_amplifier_enable = pwr_q.crystal_on;
   assign se_offset_enable = pwr_q.se_offset_on;

endmodule
`default_nettype wire

//--- rtl/pll_ref_pkg.sv
// shared constants, types and register map of the pll reference front end
// assumes: one 200 MHz system clock, byte-wide register port
package pll_ref_pkg;

   // register port geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   typedef logic [ADDR_W-1:0] reg_addr_t;
   typedef logic [DATA_W-1:0] reg_byte_t;

   // register offsets
   localparam reg_addr_t OFS_REF_DIV_LOW = 10'h011;
   localparam reg_addr_t OFS_REF_DIV_HIGH = 10'h012;
   localparam reg_addr_t OFS_PRESC_MODE = 10'h016;
   localparam reg_addr_t OFS_LOCK_OFFSET = 10'h018;
   localparam reg_addr_t OFS_SYNC_RESET = 10'h019;
   localparam reg_addr_t OFS_MONITOR_PIN = 10'h01b;
   localparam reg_addr_t OFS_REF_SELECT = 10'h01c;
   localparam reg_addr_t OFS_REF_STATUS = 10'h01f;

   // reset value of every register: inputs off
   localparam reg_byte_t RST_REG = 8'h00;

   // field positions
   localparam int REF_DIV_W = 14;
   localparam int REF_DIV_HIGH_W = REF_DIV_W - DATA_W;
   localparam int PRESC_LSB = 0;
   localparam int PRESC_MSB = 2;
   localparam int AB_RESET_BIT = 4;
   localparam int SHARED_RESET_BIT = 5;
   localparam int R_RESET_BIT = 6;
   localparam int SE_OFFSET_BIT = 7;
   localparam int SYNC_EN_LSB = 6;
   localparam int SYNC_EN_MSB = 7;
   localparam logic [1:0] SYNC_EN_OFF = 2'h0;

   // feedback counter widths
   localparam int SWALLOW_W = 6;
   localparam int MAIN_W = 13;
   localparam int PRESC_W = 6;
   localparam logic [MAIN_W-1:0] MAIN_BYPASS = 13'h0001;

   // monitor pin source codes
   localparam reg_byte_t MON_PRIMARY_BAD = 8'hf7;
   localparam reg_byte_t MON_SECONDARY_BAD = 8'hf8;

   // prescaler mode field
   typedef enum logic [2:0] {
      PRE_FIXED1 = 3'b000,
      PRE_FIXED2 = 3'b001,
      PRE_DUAL2 = 3'b010,
      PRE_DUAL4 = 3'b011,
      PRE_DUAL8 = 3'b100,
      PRE_DUAL16 = 3'b101,
      PRE_DUAL32 = 3'b110,
      PRE_FIXED3 = 3'b111
   } presc_mode_e;

   // prescaler base moduli
   localparam logic [PRESC_W-1:0] MOD_1 = 6'h01;
   localparam logic [PRESC_W-1:0] MOD_2 = 6'h02;
   localparam logic [PRESC_W-1:0] MOD_3 = 6'h03;
   localparam logic [PRESC_W-1:0] MOD_4 = 6'h04;
   localparam logic [PRESC_W-1:0] MOD_8 = 6'h08;
   localparam logic [PRESC_W-1:0] MOD_16 = 6'h10;
   localparam logic [PRESC_W-1:0] MOD_32 = 6'h20;

   // reference select register layout, bit 7 down to bit 0
   typedef struct packed {
      logic deglitch_en;
      logic pin_select;
      logic auto_en;
      logic manual_secondary;
      logic crystal_en;
      logic secondary_en;
      logic primary_en;
      logic diff_en;
   } ref_ctrl_s;

   // power and bias outputs
   typedef struct packed {
      logic diff_rx_on;
      logic se1_on;
      logic se2_on;
      logic crystal_on;
      logic se_offset_on;
   } ref_power_s;

   // selection and deglitch states
   typedef enum logic [1:0] {
      SEL_PRIMARY = 2'b00,
      SEL_SECONDARY = 2'b01,
      SEL_BLANK_TO_PRI = 2'b10,
      SEL_BLANK_TO_SEC = 2'b11
   } sel_state_e;

   // no rising edge for this long: input invalid
   localparam int CLK_PERIOD_PS = 5000;
   localparam int REF_LOSS_NS = 1000;
   localparam int REF_LOSS_CYC =
      (REF_LOSS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOSS_W = 8;
   localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(REF_LOSS_CYC);

endpackage

//--- rtl/pin_sync2.sv
// two flip-flop synchroniser for a group of asynchronous pins
// assumes: inputs are quasi-static or slower than half the system clock
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // raw pins and their synchronised copy
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);

   logic [W-1:0] meta_q; // first stage, read only by the second

   // two-stage capture
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         pin_sync <= RST_VAL;
      end else begin
         meta_q <= pin_in;
         pin_sync <= meta_q;
      end
   end

endmodule
`default_nettype wire

//--- rtl/div_counter.sv
// reloading divide-by-n counter driven by input tick pulses
// assumes: tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module div_counter #(
   parameter int W = 14
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // synchronous hold-in-reset and input events
   input wire logic clear,
   input wire logic tick,
   input wire logic [W-1:0] ratio,
   // terminal count: same-cycle wrap and registered pulse
   output logic wrap,
   output logic pulse_q
);

   logic [W-1:0] count_q; // ticks seen since last wrap
   logic [W-1:0] count_d;
   logic at_end; // next tick reaches terminal count

   // ratio zero and one both divide by one
   assign at_end = (ratio <= W'(1)) || (count_q >= ratio - W'(1));
   assign wrap = tick && at_end && !clear;

   // next count: reload on wrap, held at zero while cleared
   assign count_d = (clear || wrap) ? '0 : count_q + W'(tick);

   // counter and output pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         count_q <= count_d;
         pulse_q <= wrap;
      end
   end

endmodule
`default_nettype wire

//--- verif/ref_clk_src.sv
// model of the two external single-ended reference clock sources
// assumes: the bench starts and stops each source; a stopped one idles low
`timescale 1ns/1ps
`default_nettype none
module ref_clk_src #(
   parameter int HALF_P = 23,
   parameter int HALF_S = 31
) (
   // run controls from the bench
   input wire logic run_p,
   input wire logic run_s,
   // reference pins toward the device
   output logic ref_p,
   output logic ref_s
);
   // primary source, free of any phase tie to the system clock
   initial ref_p = 1'b0;
   always #HALF_P ref_p = run_p ? !ref_p : 1'b0;
   // secondary source on a period of its own
   initial ref_s = 1'b0;
   always #HALF_S ref_s = run_s ? !ref_s : 1'b0;
endmodule
`default_nettype wire

//--- verif/pll_ref_select_and_dividers_chk.sv
// port checker for the pll reference front end
// assumes: bound onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pll_ref_chk
   import pll_ref_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register writes
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   // pins and feedback events
   input wire logic ref_pin_p,
   input wire logic vco_tick,
   input wire logic pll_powered_down,
   // outputs under watch
   input wire logic ref_to_detector,
   input wire logic feedback_to_detector,
   input wire logic reference_monitor_pin,
   input wire logic diff_rx_power_on,
   input wire logic se1_power_on,
   input wire logic se2_power_on,
   input wire logic crystal_amplifier_enable,
   input wire logic se_offset_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // shadows of bits the outputs follow
   logic xtal_q, offs_q, mon_q, p_q;
   logic [2:0] wr_q; // recent write history
   logic [7:0] idle_q; // cycles since the primary pin last moved
   wire logic quiet = (wr_q == 3'h0) && !reg_wr;
   // shadow registers, kept off while reset is low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {xtal_q, offs_q, mon_q, p_q, wr_q, idle_q} <= '0;
      end else begin
         wr_q <= {wr_q[1:0], reg_wr};
         p_q <= ref_pin_p;
         idle_q <= (p_q != ref_pin_p) ? '0 : idle_q + 8'(idle_q != 8'hff);
         if (reg_wr && reg_addr == OFS_REF_SELECT)
            xtal_q <= reg_wdata[3];
         if (reg_wr && reg_addr == OFS_LOCK_OFFSET)
            offs_q <= reg_wdata[SE_OFFSET_BIT];
         if (reg_wr && reg_addr == OFS_MONITOR_PIN)
            mon_q <= reg_wdata == MON_PRIMARY_BAD;
      end
   end
   property p_reset_off;
      $rose(rst_n) |-> !(diff_rx_power_on || se1_power_on || se2_power_on);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("input on at reset");
   property p_pll_down;
      pll_powered_down [*2] |->
         !(diff_rx_power_on || se1_power_on || se2_power_on);
   endproperty
   a_pll_down: assert property (p_pll_down) else $error("rx on, pll down");
   property p_diff_se;
      diff_rx_power_on |-> !se1_power_on && !se2_power_on;
   endproperty
   a_diff_se: assert property (p_diff_se) else $error("se on in diff mode");
   property p_xtal; quiet |-> crystal_amplifier_enable == xtal_q; endproperty
   a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
   property p_offset; quiet |-> se_offset_enable == offs_q; endproperty
   a_offset: assert property (p_offset) else $error("offset enable wrong");
   property p_ref_pulse; ref_to_detector |=> !ref_to_detector; endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("ref pulse long");
   property p_fb_cause; feedback_to_detector |-> $past(vco_tick); endproperty
   a_fb_cause: assert property (p_fb_cause) else $error("fb without tick");
   property p_mon_high;
      mon_q && quiet && idle_q == 8'hff |-> reference_monitor_pin;
   endproperty
   a_mon_high: assert property (p_mon_high) else $error("monitor not high");
   property p_mon_low;
      mon_q && se1_power_on && $rose(ref_pin_p) |-> ##[2:12] !reference_monitor_pin;
   endproperty
   a_mon_low: assert property (p_mon_low) else $error("monitor stuck");
   // main scenarios reached
   c_ref: cover property (ref_to_detector);
   c_fb: cover property (feedback_to_detector);
   c_mon: cover property ($fell(reference_monitor_pin));
endmodule
bind pll_ref_select_and_dividers pll_ref_chk pll_ref_chk_i (.*);
`default_nettype wire

//--- verif/pll_ref_select_and_dividers_tb.sv
// self-checking bench for the pll reference front end
// assumes: source model and checker compiled alongside
`timescale 1ns/1ps
`default_nettype none
module automatic pll_ref_select_and_dividers_tb
   import pll_ref_pkg::*;
;
   // clock, reset and register port
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   reg_addr_t reg_addr = '0;
   reg_byte_t reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   reg_byte_t reg_rdata;
   // pins and feedback side
   logic ref_pin_p, ref_pin_n;
   logic run_p = 1'b1;
   logic run_s = 1'b1;
   logic ref_sel_pin = 1'b0;
   logic sync_n_pin = 1'b1;
   logic vco_tick = 1'b0;
   logic pll_powered_down = 1'b0;
   logic [SWALLOW_W-1:0] swallow_count = '0;
   logic [MAIN_W-1:0] main_count = 13'h0003;
   // design outputs
   logic ref_to_detector, feedback_to_detector, reference_monitor_pin;
   logic diff_rx_power_on, se1_power_on, se2_power_on;
   logic crystal_amplifier_enable, se_offset_enable;
   wire logic [3:0] pwr = {diff_rx_power_on, se1_power_on, se2_power_on,
      crystal_amplifier_enable};
   // tallies
   int err_total, n_checks, ref_n, fb_n, edg, g;
   // case tables
   reg_addr_t ofs [7] = '{OFS_REF_DIV_LOW, OFS_REF_DIV_HIGH, OFS_PRESC_MODE,
      OFS_LOCK_OFFSET, OFS_SYNC_RESET, OFS_MONITOR_PIN, OFS_REF_SELECT};
   int md [10] = '{0, 1, 7, 2, 3, 4, 5, 6, 3, 0}; // mode field
   int pp [10] = '{1, 2, 3, 2, 4, 8, 16, 32, 4, 1}; // base modulus
   int aa [10] = '{5, 0, 0, 1, 2, 3, 3, 3, 0, 0}; // swallow
   int bb [10] = '{3, 3, 4, 3, 3, 3, 4, 3, 1, 1}; // main
   int rr [4] = '{0, 1, 5, 257};
   reg_byte_t rb [3] = '{8'h40, 8'h20, 8'h10};
   reg_byte_t pw [4] = '{8'h01, 8'h07, 8'h06, 8'h0a};
   logic [3:0] pe [4] = '{4'h8, 4'h8, 4'h6, 4'h5};
   reg_byte_t sv [4] = '{8'h06, 8'h16, 8'h46, 8'h46};
   logic [3:0] sp = 4'h4;
   logic [3:0] ok = 4'h6;
   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;
   pll_ref_select_and_dividers pll_ref_select_and_dividers_i (.*);
   ref_clk_src ref_clk_src_i (.run_p(run_p), .run_s(run_s),
      .ref_p(ref_pin_p), .ref_s(ref_pin_n));
   // pulse and edge counts
   always @(posedge clk_sys) begin
      if (ref_to_detector === 1'b1) ref_n++;
      if (feedback_to_detector === 1'b1) fb_n++;
   end
   always @(posedge ref_pin_p) edg++;
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // n cycles, ending just after an edge
   task cyc(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task wr(input reg_addr_t a, input reg_byte_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask
   task rd(input reg_addr_t a, input reg_byte_t e);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
      cyc(1);
   endtask
   // clear tallies and run a window
   task win(input int n);
      ref_n = 0;
      fb_n = 0;
      edg = 0;
      cyc(n);
   endtask
   // cycles between two feedback pulses
   task gap(output int n);
      for (int i = 0; i < 400 && feedback_to_detector !== 1'b1; i++) cyc(1);
      cyc(1);
      for (n = 1; n < 400 && feedback_to_detector !== 1'b1; n++) cyc(1);
   endtask
   task wrap_up;
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
   initial begin
      int e;
      cyc(16);
      rst_n = 1'b1;
      cyc(2);
      foreach (ofs[k]) begin
         rd(ofs[k], RST_REG);
         wr(ofs[k], 8'h5a);
         rd(ofs[k], 8'h5a);
         wr(ofs[k], 8'h00);
      end
      wr(10'h010, 8'hff);
      rd(10'h010, 8'h00);
      foreach (pw[k]) begin
         wr(OFS_REF_SELECT, pw[k]);
         cyc(3);
         chk(pwr, pe[k]);
      end
      pll_powered_down = 1'b1;
      cyc(3);
      chk(pwr & 4'he, 4'h0);
      pll_powered_down = 1'b0;
      wr(OFS_LOCK_OFFSET, 8'h80);
      cyc(3);
      chk(se_offset_enable, 1'b1);
      // feedback ratios with a tick every cycle
      vco_tick = 1'b1;
      foreach (md[k]) begin
         swallow_count = SWALLOW_W'(aa[k]);
         main_count = MAIN_W'(bb[k]);
         wr(OFS_PRESC_MODE, 8'(md[k]) | 8'h10);
         wr(OFS_PRESC_MODE, 8'(md[k]));
         gap(g);
         e = pp[k] * bb[k] + ((md[k] inside {[2:6]}) ? aa[k] : 0);
         chk(g, e);
      end
      // reference divider on the primary input
      wr(OFS_REF_SELECT, 8'h02);
      foreach (rr[k]) begin
         wr(OFS_REF_DIV_LOW, rr[k][7:0]);
         wr(OFS_REF_DIV_HIGH, 8'(rr[k] >> 8));
         wr(OFS_PRESC_MODE, 8'h40);
         wr(OFS_PRESC_MODE, 8'h00);
         win(5000);
         e = edg / ((rr[k] < 2) ? 1 : rr[k]);
         chk(ref_n >= e - 1 && ref_n <= e + 1, 1'b1);
      end
      wr(OFS_REF_DIV_LOW, 8'h00);
      wr(OFS_REF_DIV_HIGH, 8'h00);
      main_count = 13'h0003;
      sync_n_pin = 1'b0;
      win(300);
      chk(ref_n > 0, 1'b1);
      sync_n_pin = 1'b1;
      foreach (rb[k]) begin
         wr(OFS_PRESC_MODE, rb[k]);
         rd(OFS_PRESC_MODE, rb[k]);
         cyc(6);
         win(400);
         chk({ref_n == 0, fb_n == 0}, {rb[k] != 8'h10, rb[k] != 8'h40});
      end
      wr(OFS_PRESC_MODE, 8'h00);
      wr(OFS_SYNC_RESET, 8'hc0);
      sync_n_pin = 1'b0;
      cyc(8);
      win(300);
      chk({ref_n == 0, fb_n == 0}, 2'b11);
      sync_n_pin = 1'b1;
      wr(OFS_SYNC_RESET, 8'h00);
      // manual selection by register and pin, primary dead
      wr(OFS_REF_SELECT, 8'h06);
      run_p = 1'b0;
      foreach (sv[k]) begin
         ref_sel_pin = sp[k];
         wr(OFS_REF_SELECT, sv[k]);
         cyc(8);
         win(300);
         chk(ref_n > 0, ok[k]);
      end
      // automatic revertive selection
      wr(OFS_MONITOR_PIN, MON_PRIMARY_BAD);
      wr(OFS_REF_SELECT, 8'h26);
      cyc(250);
      chk(reference_monitor_pin, 1'b1);
      win(200);
      chk(ref_n > 0, 1'b1);
      run_p = 1'b1;
      cyc(40);
      chk(reference_monitor_pin, 1'b0);
      run_s = 1'b0;
      cyc(8);
      win(200);
      chk(ref_n > 0, 1'b1);
      // deglitched switch to a dead secondary, then it wakes
      wr(OFS_REF_SELECT, 8'h86);
      wr(OFS_REF_SELECT, 8'h96);
      cyc(8);
      win(300);
      chk(ref_n, 0);
      run_s = 1'b1;
      cyc(20);
      win(300);
      chk(ref_n > 0, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
